/* File: core/ehb_arbiter.sv */
// ehb_arbiter: hold/acknowledge arbitration for the external memory interface
// Functional notes
// - bus floats at least two periods after request
// - ack falls within two periods after float
// - bus redriven two to seven periods after release
// - ack rises within two periods after redrive
// - pending transfers finish before hold grant
// - inhibit bit postpones the grant indefinitely
// - float enable picks toggling or floating clock
// - floated clock follows the bus timing
// - one enable releases every memory bus pin; the clock pins use their own enable, mem_clk_oe
// - bus need changes only after clock rising
// - interface clock from pin, cpu/4, cpu/6
// - bus floats in reset, drives sixteen periods after
// - clock one floats in reset, valid later
// - ack follows request in reset, need low
// - all groups valid within the release limit
`timescale 1ns/1ns
module ehb_arbiter (
  clock,
  rst,
  hold_req_n,
  hold_inhibit,
  clkout_float_en,
  eclk_sel,
  mem_clk_in,
  xfer_pending,
  xfer_want,
  mem_bus_oe,
  mem_clk_out,
  mem_clk_out_one,
  mem_clk_oe,
  bus_hold_ack,
  bus_need_out,
  xfer_allow
);
  input wire logic clock;
  input wire logic rst;
  input wire logic hold_req_n;
  input wire logic hold_inhibit;
  input wire logic clkout_float_en;
  input wire logic [1:0] eclk_sel;
  input wire logic mem_clk_in;
  input wire logic xfer_pending;
  input wire logic xfer_want;
  output logic mem_bus_oe;
  output logic mem_clk_out;
  output logic mem_clk_out_one;
  output logic mem_clk_oe;
  output logic bus_hold_ack;
  output logic bus_need_out;
  output logic xfer_allow;

  // counter width brought local so size casts stay plain
  localparam int CW = ehb_pkg::CNT_W;
  ehb_pkg::ehb_regs_t s_r;
  ehb_pkg::ehb_regs_t s_nxt;
  logic req_sync;
  logic pin_d_r;
  logic tick;
  logic clk_rise;

  // request crosses into the block clock before the state machine sees it
  ehb_sync u_sync (
    .clock(clock),
    .rst(rst),
    .d_in(hold_req_n),
    .q_out(req_sync)
  );

  // previous external clock level for its rising-edge tick (input is synchronous)
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_d_r <= 1'h0;
    end else begin
      pin_d_r <= mem_clk_in;
    end
  end

  // one tick per interface period from the selected source
  always_comb begin
    case (eclk_sel)
      ehb_pkg::ECLK_SEL_DIV4: tick = (s_r.div == 3'(ehb_pkg::DIV4_COUNT - 1));
      ehb_pkg::ECLK_SEL_DIV6: tick = (s_r.div == 3'(ehb_pkg::DIV6_COUNT - 1));
      default: tick = mem_clk_in && !pin_d_r;
    endcase
  end

  // the output clock rises where the tick lands
  assign clk_rise = tick;

  // next-state logic for the whole arbiter
  always_comb begin
    s_nxt = s_r;
    // divider wraps at the tick so the period is exact
    if (tick || eclk_sel == ehb_pkg::ECLK_SEL_PIN) begin
      s_nxt.div = 3'h0;
    end else begin
      s_nxt.div = s_r.div + 3'h1;
    end
    // interface-period counter used by every hold window
    if (tick && s_r.ecnt != '1) begin
      s_nxt.ecnt = s_r.ecnt + 1'b1;
    end
    // bus need only moves on an output clock rising edge
    if (clk_rise) begin
      s_nxt.need = xfer_want && s_r.bus_oe;
    end
    case (s_r.st)
      ehb_pkg::ST_RESET: begin
        // one tick beyond sixteen: the first tick may land right after release
        s_nxt.hold_ack = req_sync;
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (s_r.ecnt > CW'(ehb_pkg::RST_DRIVE_MIN_E)) begin
          s_nxt.bus_oe = 1'h1;
          s_nxt.clk_oe = 1'h1;
          s_nxt.hold_ack = 1'h1;
          s_nxt.st = ehb_pkg::ST_OWN;
        end
      end
      ehb_pkg::ST_OWN: begin
        if (!req_sync) begin
          s_nxt.ecnt = '0;
          s_nxt.st = ehb_pkg::ST_DRAIN;
        end
      end
      ehb_pkg::ST_DRAIN: begin
        // inhibit and open transfers both keep the bus here
        if (req_sync) begin
          s_nxt.st = ehb_pkg::ST_OWN; // request withdrawn before grant
        end else if (!hold_inhibit && !xfer_pending &&
                     s_r.ecnt > CW'(ehb_pkg::HIZ_MIN_E)) begin
          s_nxt.bus_oe = 1'h0;
          s_nxt.clk_oe = !clkout_float_en;
          s_nxt.ecnt = '0;
          s_nxt.st = ehb_pkg::ST_FLOAT;
        end
      end
      ehb_pkg::ST_FLOAT: begin
        // acknowledge once the bus is already floating
        s_nxt.hold_ack = 1'h0;
        s_nxt.st = ehb_pkg::ST_HELD;
      end
      ehb_pkg::ST_HELD: begin
        // the master keeps request low past the ack, so no race here
        if (req_sync) begin
          s_nxt.ecnt = '0;
          s_nxt.st = ehb_pkg::ST_RESUME;
        end
      end
      ehb_pkg::ST_RESUME: begin
        // an extra tick covers the partial first period and the sync delay
        if (s_r.ecnt > CW'(ehb_pkg::RESUME_MIN_E)) begin
          s_nxt.bus_oe = 1'h1;
          s_nxt.clk_oe = 1'h1;
          s_nxt.st = ehb_pkg::ST_UNACK;
        end
      end
      ehb_pkg::ST_UNACK: begin
        // ack rises the cycle after the bus is driven
        s_nxt.hold_ack = 1'h1;
        s_nxt.st = ehb_pkg::ST_OWN;
      end
      default: s_nxt.st = ehb_pkg::ST_RESET;
    endcase
  end

  // register the whole state; reset floats the bus and the clock
  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= ehb_pkg::ST_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // output clock level: high for the first half of the divided period
  logic clk_lvl;
  always_comb begin
    case (eclk_sel)
      ehb_pkg::ECLK_SEL_DIV4: clk_lvl = (s_r.div < 3'h2);
      ehb_pkg::ECLK_SEL_DIV6: clk_lvl = (s_r.div < 3'h3);
      default: clk_lvl = pin_d_r;
    endcase
  end

  // during reset ack mirrors the request level and need stays low
  assign bus_hold_ack = (s_r.st == ehb_pkg::ST_RESET) ? hold_req_n : s_r.hold_ack;
  assign bus_need_out = s_r.need;
  assign mem_bus_oe = s_r.bus_oe;
  assign mem_clk_oe = s_r.clk_oe;
  assign mem_clk_out = clk_lvl;
  assign mem_clk_out_one = clk_lvl;
  assign xfer_allow = s_r.bus_oe && (s_r.st == ehb_pkg::ST_OWN);

  // bus must not float before the two-period minimum after request
  a_float_after_req: assert property (@(posedge clock) disable iff (rst)
    $fell(s_r.bus_oe) |-> $past(s_r.st) == ehb_pkg::ST_DRAIN &&
      $past(s_r.ecnt) > CW'(ehb_pkg::HIZ_MIN_E))
    else $error("bus floated too early");
  // ack falls one cycle after the float
  a_ack_after_float: assert property (@(posedge clock) disable iff (rst)
    $fell(s_r.bus_oe) |-> ##1 !s_r.hold_ack)
    else $error("ack not lowered after float");
  // no float while a transfer is open
  a_no_grant_busy: assert property (@(posedge clock) disable iff (rst)
    $fell(s_r.bus_oe) |-> !$past(xfer_pending))
    else $error("granted with transfer open");
  // inhibit blocks the grant
  a_inhibit_blocks: assert property (@(posedge clock) disable iff (rst)
    $fell(s_r.bus_oe) |-> !$past(hold_inhibit))
    else $error("granted under inhibit");
  // ack rises one cycle after redrive
  a_ack_after_drive: assert property (@(posedge clock) disable iff (rst)
    $rose(s_r.bus_oe) && $past(s_r.st) == ehb_pkg::ST_RESUME |-> ##1 s_r.hold_ack)
    else $error("ack not raised after redrive");
  // clock floats only with float enable
  a_clk_float_en: assert property (@(posedge clock) disable iff (rst)
    $fell(s_r.clk_oe) |-> $past(clkout_float_en))
    else $error("clock floated without enable");
  // need changes only on a tick
  a_need_on_edge: assert property (@(posedge clock) disable iff (rst)
    $changed(s_r.need) |-> $past(clk_rise))
    else $error("need moved off edge");
  // ack low and bus floating throughout the held state
  a_ack_while_held: assert property (@(posedge clock) disable iff (rst)
    s_r.st == ehb_pkg::ST_HELD |-> !bus_hold_ack && !mem_bus_oe)
    else $error("held state inconsistent");
endmodule

/* File: core/ehb_pkg.sv */
// ehb_pkg: constants and carrier types for the external bus hold arbiter
package ehb_pkg;
  // interface clock select encodings
  localparam logic [1:0] ECLK_SEL_PIN = 2'h0;
  localparam logic [1:0] ECLK_SEL_DIV4 = 2'h1;
  localparam logic [1:0] ECLK_SEL_DIV6 = 2'h2;
  // cpu clock dividers for the interface tick
  localparam int DIV4_COUNT = 4;
  localparam int DIV6_COUNT = 6;
  // hold timing in interface clock periods (e)
  localparam int HIZ_MIN_E = 2;
  localparam int ACK_MAX_E = 2;
  localparam int RESUME_MIN_E = 2;
  localparam int RESUME_MAX_E = 7;
  // reset release timing
  localparam int RST_DRIVE_MIN_E = 16;
  localparam int RST_VALID_MAX_P = 16070;
  localparam int CLK_MHZ = 50;
  localparam int CPU_MHZ = 50;
  // cpu periods converted to block clock cycles, rounded down for a longest time
  localparam int RST_VALID_CYC = (RST_VALID_MAX_P * CLK_MHZ) / CPU_MHZ;
  localparam int CNT_W = 15;

  // memory bus drive controls (clock drive released with the bus during hold only under float enable)
  typedef struct packed {
    logic bus_oe;
    logic clk_oe;
  } ehb_drive_t;

  // arbitration states
  typedef enum logic [2:0] {
    ST_RESET,
    ST_OWN,
    ST_DRAIN,
    ST_FLOAT,
    ST_HELD,
    ST_RESUME,
    ST_UNACK
  } ehb_state_t;

  // all state of the arbiter
  typedef struct packed {
    ehb_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] ecnt;
    logic bus_oe;
    logic clk_oe;
    logic hold_ack;
    logic need;
    logic [2:0] div;
  } ehb_regs_t;
endpackage

/* File: core/ehb_sync.sv */
// ehb_sync: two-stage synchroniser for the hold request
`timescale 1ns/1ns
module ehb_sync (
  clock,
  rst,
  d_in,
  q_out
);
  input wire logic clock;
  input wire logic rst;
  input wire logic d_in;
  output logic q_out;

  // stage one is read only by stage two, idle level is high (no request)
  logic s1_r;
  logic s2_r;

  // plain double flop, reset to the idle high level
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_r <= 1'h1;
      s2_r <= 1'h1;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
    end
  end

  assign q_out = s2_r;
endmodule

/* File: dv/ehb_master_model.sv */
// ehb_master_model: outside master that asks for the memory bus
`timescale 1ns/1ns
module ehb_master_model #(
  parameter int HOLD_CYC = 10
) (
  clock,
  want,
  bus_hold_ack,
  hold_req_n
);
  input wire logic clock;
  input wire logic want;
  input wire logic bus_hold_ack;
  output logic hold_req_n;
  int low_cnt = 0; // cycles seen with ack low
  initial hold_req_n = 1'b1;
  // withdraw only a full period after ack low, or before any grant
  always @(posedge clock) begin
    low_cnt <= bus_hold_ack ? 0 : low_cnt + 1;
    if (want) begin
      hold_req_n <= 1'b0;
    end else if (bus_hold_ack || low_cnt >= HOLD_CYC) begin
      hold_req_n <= 1'b1;
    end
  end
endmodule

/* File: dv/ext_bus_hold_arbiter_tb_top.sv */
// ext_bus_hold_arbiter_tb_top: self-checking bench for the hold arbiter
`timescale 1ns/1ns
module ext_bus_hold_arbiter_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic want = 1'b0; // master asks for the bus
  logic hold_req_n;
  logic hold_inhibit = 1'b0;
  logic clkout_float_en = 1'b1;
  logic [1:0] eclk_sel = ehb_pkg::ECLK_SEL_DIV4;
  logic mem_clk_in = 1'b0;
  logic xfer_pending = 1'b0;
  logic xfer_want = 1'b0;
  logic bus_oe, clk_out, clk_oe, ack, need;
  logic clk_one, allow;
  int err_total = 0;
  int checks_done = 0;
  int e = ehb_pkg::DIV4_COUNT; // block cycles per interface tick
  always #10 clock = ~clock;
  // pin clock: ten block cycles a period
  always begin
    repeat (5) @(posedge clock);
    mem_clk_in <= ~mem_clk_in;
  end
  ehb_master_model #(.HOLD_CYC(10)) master (.clock(clock), .want(want),
    .bus_hold_ack(ack), .hold_req_n(hold_req_n));
  ehb_arbiter DUT (.clock(clock), .rst(rst), .hold_req_n(hold_req_n),
    .hold_inhibit(hold_inhibit), .clkout_float_en(clkout_float_en),
    .eclk_sel(eclk_sel), .mem_clk_in(mem_clk_in), .xfer_pending(xfer_pending),
    .xfer_want(xfer_want), .mem_bus_oe(bus_oe), .mem_clk_out(clk_out),
    .mem_clk_out_one(clk_one), .mem_clk_oe(clk_oe), .bus_hold_ack(ack),
    .bus_need_out(need), .xfer_allow(allow));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // count cycles until a watched output reaches lvl; bounded so a hang ends
  task automatic wait_for(input int sel, input logic lvl, output int n);
    n = 0;
    while ((sel == 0 ? bus_oe : sel == 1 ? ack : sel == 3 ? hold_req_n :
        sel == 4 ? clk_out : need) !== lvl) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 20000) begin
        chk(1'b0, "wait ran out");
        report_and_stop();
      end
    end
  endtask
  // reset pin state, then count the floating time after release
  task automatic t_reset(input logic [1:0] sel, input int ec, input logic w);
    int n;
    @(posedge clock);
    rst <= 1'b1;
    eclk_sel <= sel;
    want <= w;
    e = ec;
    // reset kept short here to save run time; clock select held across release
    repeat (4) @(posedge clock);
    #1;
    chk(bus_oe === 1'b0 && clk_oe === 1'b0, "driven in reset");
    chk(need === 1'b0 && ack === hold_req_n, "reset pin state");
    @(posedge clock);
    rst <= 1'b0;
    want <= 1'b0;
    wait_for(0, 1'b1, n);
    chk(n >= 16 * ec && n <= ehb_pkg::RST_VALID_CYC, "release time");
    chk(clk_oe === 1'b1, "clock one not valid");
    wait_for(1, 1'b1, n);
    $display("done reset sel %0d", sel);
  endtask
  // full grant and release; fl picks floating or running clock
  task automatic t_hold(input logic fl);
    int n;
    @(posedge clock);
    clkout_float_en <= fl;
    want <= 1'b1;
    wait_for(3, 1'b0, n);
    wait_for(0, 1'b0, n);
    chk(n >= 2 * e, "bus floated early");
    wait_for(1, 1'b0, n);
    chk(n <= 2 * e, "ack late after float");
    chk(allow === 1'b0 && clk_one === clk_out, "held outputs");
    chk(clk_oe === !fl, "clock float choice");
    if (!fl) begin
      wait_for(4, ~clk_out, n);
      chk(n <= 2 * e, "clock stopped in hold");
    end
    @(posedge clock);
    want <= 1'b0;
    wait_for(3, 1'b1, n);
    wait_for(0, 1'b1, n);
    chk(n >= 2 * e && n <= 7 * e && ack === 1'b0, "resume time");
    wait_for(1, 1'b1, n);
    chk(n <= 2 * e && clk_oe === 1'b1, "ack late after drive");
    $display("done hold float %0d", fl);
  endtask
  // grant must wait while a transfer runs or inhibit is set
  task automatic t_refuse(input logic inh);
    int n;
    @(posedge clock);
    hold_inhibit <= inh;
    xfer_pending <= !inh;
    want <= 1'b1;
    repeat (20 * e) begin
      @(posedge clock);
      #1;
      chk(bus_oe === 1'b1 && ack === 1'b1, "granted early");
    end
    hold_inhibit <= 1'b0;
    xfer_pending <= 1'b0;
    wait_for(1, 1'b0, n);
    chk(n <= 6 * e, "grant late");
    @(posedge clock);
    want <= 1'b0;
    wait_for(1, 1'b1, n);
    $display("done refuse inhibit %0d", inh);
  endtask
  task automatic t_need();
    int n;
    @(posedge clock);
    xfer_want <= 1'b1;
    wait_for(5, 1'b1, n);
    chk(n <= 2 * e, "need rise late");
    chk(allow === 1'b1, "owned bus not open");
    @(posedge clock);
    xfer_want <= 1'b0;
    wait_for(5, 1'b0, n);
    chk(n <= 2 * e, "need fall late");
    $display("done need");
  endtask
  initial begin
    t_reset(ehb_pkg::ECLK_SEL_DIV4, ehb_pkg::DIV4_COUNT, 1'b0);
    t_hold(1'b1);
    t_hold(1'b0);
    t_refuse(1'b0);
    t_refuse(1'b1);
    t_need();
    t_reset(ehb_pkg::ECLK_SEL_DIV6, ehb_pkg::DIV6_COUNT, 1'b1);
    t_hold(1'b1);
    t_reset(ehb_pkg::ECLK_SEL_PIN, 10, 1'b0);
    t_hold(1'b0);
    report_and_stop();
  end
endmodule
